/* rtl/asr_pkg.sv */
// Package with register map, command codes and timing constants of the converter command interpreter
package asr_pkg;

  // ----------------------------------------------------------------
  // Command bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_RESET     = 8'h06;
  localparam logic [7:0] CMD_START     = 8'h08;
  localparam logic [7:0] CMD_STOP      = 8'h0A;
  localparam logic [7:0] CMD_READ_RES  = 8'h12;
  localparam logic [2:0] CMD_REGISTER_READ_CMD_OP   = 3'h1;  // Top three bits of register_read_cmd
  localparam logic [2:0] CMD_REGISTER_WRITE_CMD_OP   = 3'h2;  // Top three bits of register_write_cmd

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int         NUM_REGS      = 8;
  localparam logic [4:0] ADDR_ID       = 5'h00;
  localparam logic [4:0] ADDR_STATUS   = 5'h01;
  localparam logic [4:0] ADDR_GAIN     = 5'h03;
  localparam logic [4:0] ADDR_MODE     = 5'h04;
  localparam logic [4:0] ADDR_CLKCFG   = 5'h05;

  // Identity byte, value is arbitrary
  localparam logic [7:0] ID_VALUE      = 8'h5A;

  // Field positions
  localparam int         STAT_POR_BIT  = 7;
  localparam int         STAT_RDY_BIT  = 6;
  localparam int         GAIN_AMP_HI   = 4;
  localparam int         GAIN_AMP_LO   = 3;
  localparam int         GAIN_CODE_HI  = 2;
  localparam int         MODE_SINGLE   = 5;
  localparam int         CLK_EXT_BIT   = 0;

  // Field values and reset values
  localparam logic [1:0] AMP_BYPASS    = 2'h2;
  localparam logic [2:0] GAIN_UNITY    = 3'h0;
  localparam logic [7:0] GAIN_RST      = 8'h00;
  localparam logic [7:0] MODE_RST      = 8'h00;
  localparam logic [7:0] CLKCFG_RST    = 8'h00;
  localparam logic [7:0] OTHER_RST     = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          SYS_CLK_MHZ      = 100;
  localparam int          OSC_KHZ          = 4096;
  localparam int          OSC_DIV          = (SYS_CLK_MHZ * 1000) / OSC_KHZ;
  localparam logic [12:0] RESET_DLY_TICKS  = 13'h1000;  // 4096 device clocks

endpackage

/* rtl/asr_spi_shift.sv */
// Mode 1 serial shifter: samples on falling edges, launches on rising edges
`timescale 1ns/1ns
`default_nettype none

module asr_spi_shift (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic       cs_n_i,
  input  wire logic       sclk_rise_i,
  input  wire logic       sclk_fall_i,
  input  wire logic       din_i,
  input  wire logic [7:0] tx_byte_i,
  output logic      [7:0] rx_byte_o,
  output logic            rx_valid_o,
  output logic            dout_o
);

  logic [2:0] bit_cnt_q;
  logic [7:0] rx_sh_q;
  logic [7:0] tx_sh_q;

  // ----------------------------------------------------------------
  // Receive side
  // ----------------------------------------------------------------
  // Byte framing counts falling edges, so chip select may stay low forever
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bit_cnt_q  <= 3'h0;
      rx_sh_q    <= 8'h00;
      rx_byte_o  <= 8'h00;
      rx_valid_o <= 1'b0;
    end else begin
      rx_valid_o <= 1'b0;
      if (cs_n_i) begin
        bit_cnt_q <= 3'h0;  // [RQ8]
      end else if (sclk_fall_i) begin
        rx_sh_q   <= {rx_sh_q[6:0], din_i};  // [RQ2]
        bit_cnt_q <= bit_cnt_q + 3'h1;  // [RQ15]
        if (bit_cnt_q == 3'h7) begin
          rx_byte_o  <= {rx_sh_q[6:0], din_i};
          rx_valid_o <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmit side
  // ----------------------------------------------------------------
  // First rising edge of a byte loads the next byte and launches its MSB
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_sh_q <= 8'h00;
      dout_o  <= 1'b0;
    end else if (cs_n_i) begin
      tx_sh_q <= 8'h00;
      dout_o  <= 1'b0;
    end else if (sclk_rise_i) begin
      if (bit_cnt_q == 3'h0) begin
        tx_sh_q <= {tx_byte_i[6:0], 1'b0};
        dout_o  <= tx_byte_i[7];  // [RQ2]
      end else begin
        tx_sh_q <= {tx_sh_q[6:0], 1'b0};
        dout_o  <= tx_sh_q[7];
      end
    end
  end

endmodule

`default_nettype wire

/* rtl/asr_top.sv */
// Command interpreter, register file and readout sequencing of the converter serial port
//
// Summary of operation
// [RQ1] The host waits at least 2.2 ms after supplies settle before talking to the device.
// [RQ2] The link is SPI mode 1: clock idles low, data change on rising and are sampled on falling edges.
// [RQ3] Command byte 06h returns the device to its reset state.
// [RQ4] After a reset command the host waits 4096 device clocks before the next command.
// [RQ5] The status register ready bit reads 0 once reset has completed.
// [RQ6] Writing 00h to the status register clears the power-on flag.
// [RQ7] Command byte 08h starts conversions, which continue in continuous mode until stopped.
// [RQ8] Chip select high resets the serial interface and drops any partial frame.
// [RQ9] The result ready output goes low when a new conversion result is available.
// [RQ10] After the read-result command, 16 clocks shift the 16-bit result out on the data line.
// [RQ11] Command byte 0Ah halts conversions and enters standby.
// [RQ12] Amplifier field value 10b in the gain register at 03h bypasses the amplifier.
// [RQ13] While bypassed, the effective gain is 1 whatever gain is programmed.
// [RQ14] Gains above 1 take effect only while the amplifier is enabled.
// [RQ15] The device works with chip select held low, framing bytes by clock count alone.
// [RQ16] With the start pin held low, only start and stop commands control conversions.
// [RQ17] With the internal oscillator selected, the external clock input is ignored.
`timescale 1ns/1ns
`default_nettype none

module asr_top #(
  parameter logic [12:0] RESET_TICKS = asr_pkg::RESET_DLY_TICKS
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic        cs_n_i,
  input  wire logic        sclk_i,
  input  wire logic        din_i,
  input  wire logic        start_sync_i,
  input  wire logic        ext_clk_i,
  input  wire logic [15:0] conv_data_i,
  input  wire logic        conv_valid_i,
  output logic             serial_out_with_ready_o,
  output logic             result_ready_n_o,
  output logic             conv_run_o,
  output logic             amp_bypass_o,
  output logic       [2:0] eff_gain_o,
  output logic             device_ready_o
);

  import asr_pkg::*;

  typedef enum logic [2:0] {
    ST_CMD = 3'b000,
    ST_ARG = 3'b001,
    ST_WR  = 3'b010,
    ST_RD  = 3'b011,
    ST_RES = 3'b100
  } asr_state_e;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic is_op(input logic [7:0] b, input logic [2:0] op);
    is_op = (b[7:5] == op);
  endfunction

  function automatic logic amp_is_bypassed(input logic [7:0] g);
    amp_is_bypassed = (g[GAIN_AMP_HI:GAIN_AMP_LO] == AMP_BYPASS);
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Bits: 0 cs_n, 1 sclk, 2 din, 3 start pin, 4 external clock
  logic [4:0] sync_a_q;
  logic [4:0] sync_b_q;
  logic [4:0] sync_c_q;

  // First stage feeds only the second; edges are taken from the later stages
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_a_q <= 5'h01;
      sync_b_q <= 5'h01;
      sync_c_q <= 5'h01;
    end else begin
      sync_a_q <= {ext_clk_i, start_sync_i, din_i, sclk_i, cs_n_i};
      sync_b_q <= sync_a_q;
      sync_c_q <= sync_b_q;
    end
  end

  logic cs_n_w;
  logic sclk_rise_w;
  logic sclk_fall_w;
  logic start_rise_w;
  logic ext_rise_w;

  assign cs_n_w       = sync_b_q[0];
  assign sclk_rise_w  = sync_b_q[1] & ~sync_c_q[1];
  assign sclk_fall_w  = ~sync_b_q[1] & sync_c_q[1];
  assign start_rise_w = sync_b_q[3] & ~sync_c_q[3];
  assign ext_rise_w   = sync_b_q[4] & ~sync_c_q[4];

  // ----------------------------------------------------------------
  // Serial shifter
  // ----------------------------------------------------------------
  logic [7:0] rx_byte_w;
  logic       rx_valid_w;
  logic       spi_dout_w;
  logic [7:0] tx_byte_q;

  asr_spi_shift u_shift (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n_i),
    .cs_n_i      (cs_n_w),
    .sclk_rise_i (sclk_rise_w),
    .sclk_fall_i (sclk_fall_w),
    .din_i       (sync_b_q[2]),
    .tx_byte_i   (tx_byte_q),
    .rx_byte_o   (rx_byte_w),
    .rx_valid_o  (rx_valid_w),
    .dout_o      (spi_dout_w)
  );

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  asr_state_e  state_q;
  logic  [4:0] addr_q;
  logic  [4:0] cnt_q;
  logic        op_rd_q;
  logic        tx_active_q;
  logic  [7:0] regs_q [NUM_REGS];
  logic        power_on_q;
  logic        ready_n_q;
  logic [15:0] result_q;
  logic        res_ready_n_q;
  logic        run_q;

  logic cmd_byte_w;
  logic cmd_reset_w;
  logic cmd_start_w;
  logic cmd_stop_w;
  logic cmd_rdres_w;
  logic wr_en_w;

  assign cmd_byte_w  = rx_valid_w & (state_q == ST_CMD);
  assign cmd_reset_w = cmd_byte_w & (rx_byte_w == CMD_RESET);  // [RQ3]
  assign cmd_start_w = cmd_byte_w & (rx_byte_w == CMD_START);  // [RQ7]
  assign cmd_stop_w  = cmd_byte_w & (rx_byte_w == CMD_STOP);  // [RQ11]
  assign cmd_rdres_w = cmd_byte_w & (rx_byte_w == CMD_READ_RES);  // [RQ10]
  assign wr_en_w     = rx_valid_w & (state_q == ST_WR);

  // Register read mux; addresses from NUM_REGS up read zero
  function automatic logic [7:0] reg_read(input logic [4:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == ADDR_ID) begin
      v = ID_VALUE;
    end else if (a == ADDR_STATUS) begin
      v[STAT_POR_BIT] = power_on_q;
      v[STAT_RDY_BIT] = ready_n_q;  // [RQ5]
    end else if (a < 5'(NUM_REGS)) begin
      v = regs_q[a[2:0]];
    end
    reg_read = v;
  endfunction

  // ----------------------------------------------------------------
  // Frame state machine
  // ----------------------------------------------------------------
  // Chip select high drops whatever frame was in progress
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q     <= ST_CMD;
      addr_q      <= 5'h00;
      cnt_q       <= 5'h00;
      op_rd_q     <= 1'b0;
      tx_active_q <= 1'b0;
      tx_byte_q   <= 8'h00;
    end else if (cs_n_w) begin
      state_q     <= ST_CMD;  // [RQ8]
      tx_active_q <= 1'b0;
    end else if (rx_valid_w) begin
      unique case (state_q)
        ST_CMD: begin
          if (cmd_rdres_w) begin
            tx_byte_q   <= result_q[15:8];  // [RQ10]
            tx_active_q <= 1'b1;
            cnt_q       <= 5'h00;
            state_q     <= ST_RES;
          end else if (is_op(rx_byte_w, CMD_REGISTER_READ_CMD_OP) || is_op(rx_byte_w, CMD_REGISTER_WRITE_CMD_OP)) begin
            addr_q  <= rx_byte_w[4:0];
            op_rd_q <= is_op(rx_byte_w, CMD_REGISTER_READ_CMD_OP);
            state_q <= ST_ARG;
          end
        end
        ST_ARG: begin
          cnt_q <= rx_byte_w[4:0];
          if (op_rd_q) begin
            tx_byte_q   <= reg_read(addr_q);
            tx_active_q <= 1'b1;
            state_q     <= ST_RD;
          end else begin
            state_q <= ST_WR;
          end
        end
        ST_WR, ST_RD: begin
          addr_q    <= addr_q + 5'h01;
          tx_byte_q <= reg_read(addr_q + 5'h01);
          if (cnt_q == 5'h00) begin
            state_q     <= ST_CMD;
            tx_active_q <= 1'b0;
          end else begin
            cnt_q <= cnt_q - 5'h01;
          end
        end
        ST_RES: begin
          // Second byte of the 16-bit result, then back to command
          if (cnt_q == 5'h00) begin
            tx_byte_q <= result_q[7:0];  // [RQ10]
            cnt_q     <= 5'h01;
          end else begin
            state_q     <= ST_CMD;
            tx_active_q <= 1'b0;
          end
        end
        default: begin
          state_q     <= ST_CMD;
          tx_active_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Identity and status are not stored here; writes to identity are dropped
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_q[i] <= OTHER_RST;
      end
      regs_q[ADDR_GAIN[2:0]]   <= GAIN_RST;
      regs_q[ADDR_MODE[2:0]]   <= MODE_RST;
      regs_q[ADDR_CLKCFG[2:0]] <= CLKCFG_RST;
    end else if (cmd_reset_w) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_q[i] <= OTHER_RST;
      end
      regs_q[ADDR_GAIN[2:0]]   <= GAIN_RST;  // [RQ3]
      regs_q[ADDR_MODE[2:0]]   <= MODE_RST;
      regs_q[ADDR_CLKCFG[2:0]] <= CLKCFG_RST;
    end else if (wr_en_w && addr_q > ADDR_STATUS && addr_q < 5'(NUM_REGS)) begin
      regs_q[addr_q[2:0]] <= rx_byte_w;  // [RQ12]
    end
  end

  // Power-on flag: set by any reset, cleared by writing zero to status
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      power_on_q <= 1'b1;
    end else if (cmd_reset_w) begin
      power_on_q <= 1'b1;
    end else if (wr_en_w && addr_q == ADDR_STATUS) begin
      power_on_q <= rx_byte_w[STAT_POR_BIT];  // [RQ6]
    end
  end

  // ----------------------------------------------------------------
  // Device clock and reset delay
  // ----------------------------------------------------------------
  logic  [6:0] osc_cnt_q;
  logic        osc_tick_q;
  logic        dev_tick_w;
  logic [12:0] rst_cnt_q;

  // Internal oscillator is a divider; its rate is close to, not exactly, nominal
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osc_cnt_q  <= 7'h00;
      osc_tick_q <= 1'b0;
    end else if (osc_cnt_q == 7'(OSC_DIV - 1)) begin
      osc_cnt_q  <= 7'h00;
      osc_tick_q <= 1'b1;
    end else begin
      osc_cnt_q  <= osc_cnt_q + 7'h01;
      osc_tick_q <= 1'b0;
    end
  end

  // External clock edges count only when selected
  assign dev_tick_w = regs_q[ADDR_CLKCFG[2:0]][CLK_EXT_BIT] ? ext_rise_w : osc_tick_q;  // [RQ17]

  // Ready bit stays high for the reset delay; commands are not blocked meanwhile
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_cnt_q <= RESET_TICKS;
      ready_n_q <= 1'b1;
    end else if (cmd_reset_w) begin
      rst_cnt_q <= RESET_TICKS;  // [RQ4]
      ready_n_q <= 1'b1;
    end else if (dev_tick_w && ready_n_q) begin
      if (rst_cnt_q <= 13'h0001) begin
        rst_cnt_q <= 13'h0000;
        ready_n_q <= 1'b0;  // [RQ5]
      end else begin
        rst_cnt_q <= rst_cnt_q - 13'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Conversion control and result capture
  // ----------------------------------------------------------------
  // Start pin only adds a start on its rising edge; held low it does nothing
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_q <= 1'b0;
    end else if (cmd_reset_w || cmd_stop_w) begin
      run_q <= 1'b0;  // [RQ11]
    end else if (cmd_start_w || start_rise_w) begin
      run_q <= 1'b1;  // [RQ16]
    end else if (run_q && conv_valid_i && regs_q[ADDR_MODE[2:0]][MODE_SINGLE]) begin
      run_q <= 1'b0;  // [RQ7]
    end
  end

  // A new result wins over the release caused by a read in the same cycle
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      result_q      <= 16'h0000;
      res_ready_n_q <= 1'b1;
    end else if (run_q && conv_valid_i && !cmd_reset_w) begin
      result_q      <= conv_data_i;
      res_ready_n_q <= 1'b0;  // [RQ9]
    end else if (cmd_rdres_w || cmd_stop_w || cmd_reset_w) begin
      res_ready_n_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  // Data line shows the ready level whenever no reply is being shifted
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      serial_out_with_ready_o <= 1'b1;
      result_ready_n_o        <= 1'b1;
      conv_run_o              <= 1'b0;
      device_ready_o          <= 1'b0;
    end else begin
      serial_out_with_ready_o <= tx_active_q ? spi_dout_w : res_ready_n_q;  // [RQ10]
      result_ready_n_o        <= res_ready_n_q;  // [RQ9]
      conv_run_o              <= run_q;
      device_ready_o          <= ~ready_n_q;
    end
  end

  // Bypass forces unity gain so a stale gain code cannot leak through
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      amp_bypass_o <= 1'b0;
      eff_gain_o   <= GAIN_UNITY;
    end else begin
      amp_bypass_o <= amp_is_bypassed(regs_q[ADDR_GAIN[2:0]]);  // [RQ12]
      if (amp_is_bypassed(regs_q[ADDR_GAIN[2:0]])) begin
        eff_gain_o <= GAIN_UNITY;  // [RQ13]
      end else begin
        eff_gain_o <= regs_q[ADDR_GAIN[2:0]][GAIN_CODE_HI:0];  // [RQ14]
      end
    end
  end

endmodule

`default_nettype wire

/* testbench/asr_top_monitor.sv */
// Checker watching the ports of the converter command interpreter
`timescale 1ns/1ns
`default_nettype none

module asr_top_monitor #(
  parameter logic [12:0] RESET_TICKS = 13'h1000
) (
  input wire logic        clk_sys_i,
  input wire logic        rst_n_i,
  input wire logic        cs_n_i,
  input wire logic        sclk_i,
  input wire logic        din_i,
  input wire logic        start_sync_i,
  input wire logic        ext_clk_i,
  input wire logic [15:0] conv_data_i,
  input wire logic        conv_valid_i,
  input wire logic        serial_out_with_ready_o,
  input wire logic        result_ready_n_o,
  input wire logic        conv_run_o,
  input wire logic        amp_bypass_o,
  input wire logic [2:0]  eff_gain_o,
  input wire logic        device_ready_o
);
  logic [4:0] idle_q;

  // Cycles since the serial clock was last high; no command can land while it is large
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      idle_q <= 5'h00;
    end else if (sclk_i) begin
      idle_q <= 5'h00;
    end else if (idle_q != 5'h1F) begin
      idle_q <= idle_q + 5'h01;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  // Result capture and an idle pulse while stopped
  sequence s_capture;
    conv_run_o && conv_valid_i ##1 conv_run_o;
  endsequence
  sequence s_idle_pulse;
    result_ready_n_o && conv_valid_i && !conv_run_o ##1 !conv_run_o [*2];
  endsequence

  a_reset_values: assert property ($rose(rst_n_i) |-> serial_out_with_ready_o && result_ready_n_o && !conv_run_o
    && !amp_bypass_o && eff_gain_o == 3'h0 && !device_ready_o) else $error("outputs not at reset values");
  a_bypass_unity: assert property (amp_bypass_o |-> eff_gain_o == 3'h0)
    else $error("gain not unity while bypassed");
  a_ready_on_line: assert property ((cs_n_i && $stable(result_ready_n_o)) [*8]
    |-> serial_out_with_ready_o == result_ready_n_o) else $error("data line not showing ready");
  a_result_fresh: assert property (s_capture |-> ##[0:2] !result_ready_n_o)
    else $error("new result not flagged");
  a_idle_ignored: assert property (s_idle_pulse |-> result_ready_n_o)
    else $error("result taken while stopped");
  a_pin_starts: assert property ($rose(start_sync_i) |-> ##[1:8] conv_run_o)
    else $error("start pin did not start");
  a_run_continues: assert property (idle_q >= 5'h0C && $past(conv_run_o) |-> conv_run_o)
    else $error("conversion stopped without command");
  a_gain_steady: assert property (idle_q >= 5'h0C |-> $stable(amp_bypass_o) && $stable(eff_gain_o))
    else $error("gain changed without command");
endmodule

bind asr_top asr_top_monitor #(.RESET_TICKS(RESET_TICKS)) asr_top_monitor_inst (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i), .sclk_i(sclk_i), .din_i(din_i),
  .start_sync_i(start_sync_i), .ext_clk_i(ext_clk_i), .conv_data_i(conv_data_i), .conv_valid_i(conv_valid_i),
  .serial_out_with_ready_o(serial_out_with_ready_o), .result_ready_n_o(result_ready_n_o),
  .conv_run_o(conv_run_o), .amp_bypass_o(amp_bypass_o), .eff_gain_o(eff_gain_o), .device_ready_o(device_ready_o));
`default_nettype wire

/* testbench/asr_host_model.sv */
// Host controller model driving the converter serial port in mode 1
`timescale 1ns/1ns
`default_nettype none

module asr_host_model #(
  parameter int HALF = 20  // System cycles per half serial period
) (
  input  wire logic clk_sys_i,
  input  wire logic miso_i,
  output logic      cs_n_o,
  output logic      sclk_o,
  output logic      mosi_o
);
  // Serial clock idles low and stands still outside frames
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    mosi_o = 1'b0;
  end

  // Pins change just after a system clock edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic select(input logic lvl);
    tick(HALF);
    cs_n_o = lvl;
    tick(HALF);
  endtask

  // MSB first; n bits only, so a frame can be cut short
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      sclk_o = 1'b1;
      mosi_o = tx[i];
      tick(HALF);
      sclk_o = 1'b0;
      rx[i]  = miso_i;
      tick(HALF);
    end
    mosi_o = ~mosi_o;  // No stale bit left on the line
    tick(1);  // Next byte drives the line in a later time step
  endtask
endmodule
`default_nettype wire

/* testbench/tb_asr_top.sv */
// Self-checking bench for the converter command interpreter
`timescale 1ns/1ns
`default_nettype none

module tb_asr_top;
  import asr_pkg::*;
  localparam logic [12:0] TICKS = 13'h0004;  // Short reset delay keeps the run brief
  localparam int          LIMIT = 90000;

  logic        clk_sys_i;
  logic        rst_n_i;
  logic        start_sync_i;
  logic        ext_clk_i;
  logic        conv_valid_i;
  logic [15:0] conv_data_i;
  logic        cs_n, sclk, din, sout, rdy_n, run, byp, dev_rdy;
  logic [2:0]  eff;
  logic [7:0]  rx, hi, v;
  int          fail_count = 0, checked = 0, cycles = 0, seed, por_m, gain_m;
  int          res_q[$];

  asr_top #(.RESET_TICKS(TICKS)) asr_top_inst (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n), .sclk_i(sclk), .din_i(din),
    .start_sync_i(start_sync_i), .ext_clk_i(ext_clk_i), .conv_data_i(conv_data_i), .conv_valid_i(conv_valid_i),
    .serial_out_with_ready_o(sout), .result_ready_n_o(rdy_n), .conv_run_o(run), .amp_bypass_o(byp),
    .eff_gain_o(eff), .device_ready_o(dev_rdy));
  asr_host_model asr_host_model_inst (
    .clk_sys_i(clk_sys_i), .miso_i(sout), .cs_n_o(cs_n), .sclk_o(sclk), .mosi_o(din));

  // Clock, a fast external clock that must be ignored, and the hang limit
  always #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    #1 ext_clk_i = ~ext_clk_i;
  end
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      fail_count++;
      end_of_test();
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One framed transfer of up to three bytes; rx keeps the last byte
  task automatic frame(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2, input int nb);
    asr_host_model_inst.select(1'b0);
    asr_host_model_inst.xfer(b0, 8, rx);
    if (nb > 1) asr_host_model_inst.xfer(b1, 8, rx);
    if (nb > 2) asr_host_model_inst.xfer(b2, 8, rx);
    asr_host_model_inst.select(1'b1);
  endtask

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    rst_n_i = 1'b0;
    start_sync_i = 1'b0;
    ext_clk_i = 1'b0;
    conv_valid_i = 1'b0;
    conv_data_i = 16'h0000;
    seed = 32'h19F8;
    por_m = 1;
    gain_m = GAIN_RST;
    repeat (12) @(posedge clk_sys_i);
    #1 rst_n_i = 1'b1;
    repeat (300) @(posedge clk_sys_i);
    #1;
    check(16'(dev_rdy), 16'h0001);
    frame({CMD_REGISTER_READ_CMD_OP, ADDR_STATUS}, 8'h00, 8'h00, 3);
    check(16'(rx), 16'({por_m[0], 7'h00}));
    frame({CMD_REGISTER_WRITE_CMD_OP, ADDR_STATUS}, 8'h00, 8'h00, 3);
    por_m = 0;
    frame({CMD_REGISTER_READ_CMD_OP, ADDR_STATUS}, 8'h00, 8'h00, 3);
    check(16'(rx), 16'({por_m[0], 7'h00}));
    // Identity is read-only, unmapped places read zero
    frame({CMD_REGISTER_WRITE_CMD_OP, ADDR_ID}, 8'h00, 8'hFF, 3);
    frame({CMD_REGISTER_READ_CMD_OP, ADDR_ID}, 8'h00, 8'h00, 3);
    check(16'(rx), 16'(ID_VALUE));
    frame({CMD_REGISTER_READ_CMD_OP, 5'h1F}, 8'h00, 8'h00, 3);
    check(16'(rx), 16'h0000);
    // Every amplifier field value with a gain code above unity
    for (int i = 0; i < 4; i++) begin
      v = {3'h0, i[1:0], 3'($random(seed)) | 3'h4};
      gain_m = v;
      frame({CMD_REGISTER_WRITE_CMD_OP, ADDR_GAIN}, 8'h00, v, 3);
      frame({CMD_REGISTER_READ_CMD_OP, ADDR_GAIN}, 8'h00, 8'h00, 3);
      check(16'(rx), 16'(gain_m));
      check(16'(byp), 16'(i == 2));
      check(16'(eff), (i == 2) ? 16'h0000 : 16'(gain_m % 8));
    end
    // Reset command; a counted external clock would end the delay far too soon
    frame(CMD_RESET, 8'h00, 8'h00, 1);
    gain_m = GAIN_RST;
    check(16'(dev_rdy), 16'h0000);
    repeat (300) @(posedge clk_sys_i);
    #1;
    check(16'(dev_rdy), 16'h0001);
    frame({CMD_REGISTER_READ_CMD_OP, ADDR_STATUS}, 8'h00, 8'h00, 3);
    check(16'(rx[STAT_RDY_BIT]), 16'h0000);
    check(16'({byp, eff}), 16'h0000);
    // Cut frame, then a fresh read must decode cleanly
    asr_host_model_inst.select(1'b0);
    asr_host_model_inst.xfer({CMD_REGISTER_WRITE_CMD_OP, ADDR_GAIN}, 4, rx);
    asr_host_model_inst.select(1'b1);
    frame({CMD_REGISTER_READ_CMD_OP, ADDR_GAIN}, 8'h00, 8'h00, 3);
    check(16'(rx), 16'(gain_m));
    // Continuous conversions, each result read before the next arrives
    frame(CMD_START, 8'h00, 8'h00, 1);
    check(16'(run), 16'h0001);
    for (int k = 0; k < 3; k++) begin
      conv_data_i = 16'($random(seed));
      res_q.push_back(conv_data_i);
      conv_valid_i = 1'b1;
      @(posedge clk_sys_i);
      #1 conv_valid_i = 1'b0;
      repeat (4) @(posedge clk_sys_i);
      #1;
      check(16'({rdy_n, sout}), 16'h0000);
      asr_host_model_inst.select(1'b0);
      asr_host_model_inst.xfer(CMD_READ_RES, 8, rx);
      check(16'(rdy_n), 16'h0001);
      asr_host_model_inst.xfer(8'h00, 8, hi);
      asr_host_model_inst.xfer(8'h00, 8, rx);
      asr_host_model_inst.select(1'b1);
      check({hi, rx}, 16'(res_q.pop_front()));
      check(16'(run), 16'h0001);
    end
    frame(CMD_STOP, 8'h00, 8'h00, 1);
    check(16'(run), 16'h0000);
    conv_valid_i = 1'b1;
    @(posedge clk_sys_i);
    #1 conv_valid_i = 1'b0;
    repeat (4) @(posedge clk_sys_i);
    #1;
    check(16'(rdy_n), 16'h0001);
    // Start pin rise, then commands alone once it is low again
    start_sync_i = 1'b1;
    repeat (10) @(posedge clk_sys_i);
    #1;
    check(16'(run), 16'h0001);
    start_sync_i = 1'b0;
    frame(CMD_STOP, 8'h00, 8'h00, 1);
    check(16'(run), 16'h0000);
    // Select held low throughout: bytes framed by clock count
    asr_host_model_inst.select(1'b0);
    asr_host_model_inst.xfer({CMD_REGISTER_READ_CMD_OP, ADDR_ID}, 8, rx);
    asr_host_model_inst.xfer(8'h00, 8, rx);
    asr_host_model_inst.xfer(8'h00, 8, rx);
    check(16'(rx), 16'(ID_VALUE));
    asr_host_model_inst.xfer(CMD_START, 8, rx);
    asr_host_model_inst.tick(20);
    check(16'(run), 16'h0001);
    end_of_test();
  end
endmodule
`default_nettype wire
